/* hdl/dbe_top.sv */
// Debug event detection, status recording and debug mode signalling
`timescale 1ns/1ps
`include "dbe_map.svh"
module dbe_top
	import dbe_pkg::*;
(
	input  wire logic                   i_clock,
	input  wire logic                   i_rst,
	// Pipeline: instruction whose execution is attempted
	input  wire logic                   i_instr_valid,
	input  wire logic [`DBE_ADDR_W-1:0] i_instr_addr,
	input  wire logic                   i_problem_state_bit,
	input  wire logic                   i_branch_taken,
	input  wire logic                   i_trap_taken,
	input  wire logic                   i_return_exec,
	input  wire logic                   i_instr_complete,
	input  wire logic                   i_interrupt_taken,
	// Pipeline: storage access
	input  wire logic                   i_ls_valid,
	input  wire logic                   i_ls_write,
	input  wire logic [`DBE_ADDR_W-1:0] i_ls_addr,
	input  wire logic [`DBE_DATA_W-1:0] i_ls_data,
	// External debug interface, asynchronous pin
	input  wire logic                   i_uncond_request,
	// First control register fields
	input  wire logic                   i_internal_mode,
	input  wire logic                   i_external_mode,
	input  wire logic [3:0]             i_iac_enable,
	input  wire logic [1:0]             i_dac_read_enable,
	input  wire logic [1:0]             i_dac_write_enable,
	input  wire logic                   i_branch_enable,
	input  wire logic                   i_trap_enable,
	input  wire logic                   i_return_enable,
	input  wire logic                   i_instr_complete_event_enable,
	input  wire logic                   i_interrupt_event_enable,
	// Second control register fields
	input  wire logic [1:0]             i_pair_a_compare_mode,
	input  wire logic [1:0]             i_pair_b_compare_mode,
	input  wire logic [1:0]             i_comparator1_privilege_filter,
	input  wire logic [1:0]             i_comparator2_privilege_filter,
	input  wire logic [1:0]             i_comparator3_privilege_filter,
	input  wire logic [1:0]             i_comparator4_privilege_filter,
	input  wire logic                   i_pair_a_toggle_enable,
	input  wire logic                   i_pair_b_toggle_enable,
	// Third control register fields
	input  wire logic [1:0]             i_dvc_enable,
	// Comparator values
	input  wire logic [`DBE_ADDR_W-1:0] i_instr_addr_compare1,
	input  wire logic [`DBE_ADDR_W-1:0] i_instr_addr_compare2,
	input  wire logic [`DBE_ADDR_W-1:0] i_instr_addr_compare3,
	input  wire logic [`DBE_ADDR_W-1:0] i_instr_addr_compare4,
	input  wire logic [`DBE_ADDR_W-1:0] i_data_addr_compare1,
	input  wire logic [`DBE_ADDR_W-1:0] i_data_addr_compare2,
	input  wire logic [`DBE_DATA_W-1:0] i_data_value_compare1,
	input  wire logic [`DBE_DATA_W-1:0] i_data_value_compare2,
	// Machine state and wait mode
	input  wire logic                   i_debug_int_allowed,
	input  wire logic                   i_wait_mode,
	// Status clear, one bit per status bit, write one to clear
	input  wire logic [`DBE_STATUS_W-1:0] i_status_clear,
	// Results
	output logic      [`DBE_STATUS_W-1:0] o_debug_event_status,
	output logic                          o_trace_event,
	output logic                          o_stop_request,
	output logic                          o_debug_int_request
);
	////////////////////////////////////////////////////////////////////////
	// State and intermediate signals
	dbe_state_type state_q;
	dbe_state_type state_d;

	logic                     uncond_level;
	logic [1:0]               hit_a;
	logic [1:0]               hit_b;
	logic [3:0]               iac_event;
	logic [1:0]               dac_match;
	logic [1:0]               dac_rd_event;
	logic [1:0]               dac_wr_event;
	logic [1:0]               dvc_event;
	logic                     uncond_event;
	logic [`DBE_STATUS_W-1:0] set_vec;
	logic                     any_event;
	logic                     tog_a_flip;
	logic                     tog_b_flip;

	////////////////////////////////////////////////////////////////////////
	// Synchroniser for the external request pin
	dbe_sync u_uncond_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async (i_uncond_request),
		.o_level (uncond_level)
	);

	////////////////////////////////////////////////////////////////////////
	// Instruction address comparator pairs
	dbe_iac_pair u_pair_a (
		.i_addr      (i_instr_addr),
		.i_lo        (i_instr_addr_compare1),
		.i_hi        (i_instr_addr_compare2),
		.i_mode      (i_pair_a_compare_mode),
		.i_toggle_en (i_pair_a_toggle_enable),
		.i_toggle_st (state_q.status[`DBE_ST_TOG_A]),
		.i_priv_lo   (i_comparator1_privilege_filter),
		.i_priv_hi   (i_comparator2_privilege_filter),
		.i_problem   (i_problem_state_bit),
		.o_hit       (hit_a)
	);

	dbe_iac_pair u_pair_b (
		.i_addr      (i_instr_addr),
		.i_lo        (i_instr_addr_compare3),
		.i_hi        (i_instr_addr_compare4),
		.i_mode      (i_pair_b_compare_mode),
		.i_toggle_en (i_pair_b_toggle_enable),
		.i_toggle_st (state_q.status[`DBE_ST_TOG_B]),
		.i_priv_lo   (i_comparator3_privilege_filter),
		.i_priv_hi   (i_comparator4_privilege_filter),
		.i_problem   (i_problem_state_bit),
		.o_hit       (hit_b)
	);

	////////////////////////////////////////////////////////////////////////
	// Event qualification
	always_comb begin
		// Each comparator fires only when enabled; range hits reach
		// only the enabled members of the pair
		iac_event = {hit_b, hit_a} & i_iac_enable
			& {4{i_instr_valid}};

		dac_match[0] = i_ls_addr == i_data_addr_compare1;
		dac_match[1] = i_ls_addr == i_data_addr_compare2;

		// Cache management operations arrive flagged as writes
		dac_rd_event = dac_match & i_dac_read_enable
			& {2{i_ls_valid & ~i_ls_write}};
		dac_wr_event = dac_match & i_dac_write_enable
			& {2{i_ls_valid & i_ls_write}};

		// Value compare rides on a satisfied address condition
		dvc_event[0] = (dac_rd_event[0] | dac_wr_event[0])
			& i_dvc_enable[0]
			& (i_ls_data == i_data_value_compare1);
		dvc_event[1] = (dac_rd_event[1] | dac_wr_event[1])
			& i_dvc_enable[1]
			& (i_ls_data == i_data_value_compare2);

		// Request counts once per assertion, no enable involved
		uncond_event = uncond_level & ~state_q.uncond_prev;

		tog_a_flip = i_pair_a_toggle_enable
			& (|iac_event[1:0]);
		tog_b_flip = i_pair_b_toggle_enable
			& (|iac_event[3:2]);
	end

	////////////////////////////////////////////////////////////////////////
	// Status set vector
	always_comb begin
		set_vec = '0;
		set_vec[`DBE_ST_IAC +: 4] = iac_event;
		set_vec[`DBE_ST_DAC_RD +: 2] = dac_rd_event;
		set_vec[`DBE_ST_DAC_WR +: 2] = dac_wr_event;
		set_vec[`DBE_ST_DVC +: 2] = dvc_event;
		set_vec[`DBE_ST_BRANCH] = i_instr_valid & i_branch_taken
			& i_branch_enable;
		set_vec[`DBE_ST_TRAP] = i_instr_valid & i_trap_taken
			& i_trap_enable;
		set_vec[`DBE_ST_RETURN] = i_instr_valid & i_return_exec
			& i_return_enable;
		set_vec[`DBE_ST_INSTR_COMPLETE_EVENT] = i_instr_complete
			& i_instr_complete_event_enable;
		set_vec[`DBE_ST_INTERRUPT_EVENT] = i_interrupt_taken
			& i_interrupt_event_enable;
		set_vec[`DBE_ST_UNCOND] = uncond_event;
		any_event = |set_vec;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_d = state_q;
		state_d.uncond_prev = uncond_level;

		// Sticky bits; a new event wins over a clear in the same cycle
		state_d.status = (state_q.status & ~i_status_clear)
			| set_vec;

		// Toggle status inverts as the pair event is recorded
		if (tog_a_flip) begin
			state_d.status[`DBE_ST_TOG_A] =
				~state_q.status[`DBE_ST_TOG_A];
		end
		if (tog_b_flip) begin
			state_d.status[`DBE_ST_TOG_B] =
				~state_q.status[`DBE_ST_TOG_B];
		end

		// Every recorded event goes to the trace interface
		state_d.trace = any_event;

		// External mode stops first; wait mode stops unless an
		// enabled debug interrupt in internal mode takes over
		state_d.stop = any_event & (i_external_mode
			| (i_wait_mode
			& ~(i_internal_mode & i_debug_int_allowed)));
		state_d.debug_int = any_event & i_internal_mode
			& i_debug_int_allowed & ~i_external_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign o_debug_event_status = state_q.status;
	assign o_trace_event        = state_q.trace;
	assign o_stop_request       = state_q.stop;
	assign o_debug_int_request  = state_q.debug_int;
endmodule : dbe_top

/* hdl/dbe_map.svh */
// Bit positions, widths and encodings of the debug event logic
`ifndef DBE_MAP_SVH
`define DBE_MAP_SVH

`define DBE_ADDR_W      32
`define DBE_DATA_W      32
`define DBE_NUM_IAC     4
`define DBE_NUM_DAC     2

`define DBE_ST_IAC      0
`define DBE_ST_DAC_RD   4
`define DBE_ST_DAC_WR   6
`define DBE_ST_DVC      8
`define DBE_ST_BRANCH   10
`define DBE_ST_TRAP     11
`define DBE_ST_RETURN   12
`define DBE_ST_INSTR_COMPLETE_EVENT     13
`define DBE_ST_INTERRUPT_EVENT     14
`define DBE_ST_UNCOND   15
`define DBE_ST_TOG_A    16
`define DBE_ST_TOG_B    17
`define DBE_STATUS_W    18
`define DBE_STATUS_RST  18'h00000

`define DBE_SYNC_DEPTH  3

`endif

/* hdl/dbe_pkg.sv */
// Types shared by the debug event logic
package dbe_pkg;
	`include "dbe_map.svh"

	typedef enum logic [1:0] {
		DBE_CMP_EXACT    = 2'h0,
		DBE_CMP_RESERVED = 2'h1,
		DBE_CMP_INCL     = 2'h2,
		DBE_CMP_EXCL     = 2'h3
	} dbe_cmp_mode_type;

	typedef enum logic [1:0] {
		DBE_PRIV_ANY      = 2'h0,
		DBE_PRIV_RESERVED = 2'h1,
		DBE_PRIV_SUPER    = 2'h2,
		DBE_PRIV_USER     = 2'h3
	} dbe_priv_type;

	typedef struct packed {
		logic [`DBE_SYNC_DEPTH-1:0] stage;
		logic                       level;
	} dbe_sync_state_type;

	typedef struct packed {
		logic [`DBE_STATUS_W-1:0] status;
		logic                     uncond_prev;
		logic                     trace;
		logic                     stop;
		logic                     debug_int;
	} dbe_state_type;
endpackage : dbe_pkg

/* hdl/dbe_sync.sv */
// Three-stage synchroniser whose level changes once stages two and three agree
`timescale 1ns/1ps
module dbe_sync
	import dbe_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_rst,
	input  wire logic i_async,
	output logic      o_level
);
	dbe_sync_state_type state_q;
	dbe_sync_state_type state_d;

	always_comb begin
		state_d = state_q;
		state_d.stage = {state_q.stage[1:0], i_async};
		if (state_q.stage[1] == state_q.stage[2]) begin
			state_d.level = state_q.stage[2];
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_level = state_q.level;
endmodule : dbe_sync

/* hdl/dbe_iac_pair.sv */
// Address comparison for one pair of instruction address comparators
`timescale 1ns/1ps
`include "dbe_map.svh"
module dbe_iac_pair
	import dbe_pkg::*;
(
	input  wire logic [`DBE_ADDR_W-1:0] i_addr,
	input  wire logic [`DBE_ADDR_W-1:0] i_lo,
	input  wire logic [`DBE_ADDR_W-1:0] i_hi,
	input  wire logic [1:0]             i_mode,
	input  wire logic                   i_toggle_en,
	input  wire logic                   i_toggle_st,
	input  wire logic [1:0]             i_priv_lo,
	input  wire logic [1:0]             i_priv_hi,
	input  wire logic                   i_problem,
	output logic      [1:0]             o_hit
);
	logic [1:0] eff_mode;
	logic       in_range;
	logic [1:0] priv_ok;

	function automatic logic priv_match(input logic [1:0] f,
	                                    input logic p);
		case (f)
			DBE_PRIV_ANY:   priv_match = 1'b1;
			DBE_PRIV_SUPER: priv_match = ~p;
			DBE_PRIV_USER:  priv_match = p;
			default:        priv_match = 1'b0;
		endcase
	endfunction : priv_match

	always_comb begin
		eff_mode = i_mode;
		if (i_toggle_en && i_toggle_st && i_mode[1]) begin
			eff_mode[0] = ~i_mode[0];
		end
		in_range = (i_addr >= i_lo) && (i_addr < i_hi);
		priv_ok = {priv_match(i_priv_hi, i_problem),
		           priv_match(i_priv_lo, i_problem)};
		case (eff_mode)
			DBE_CMP_EXACT: begin
				o_hit = {i_addr == i_hi, i_addr == i_lo};
			end
			DBE_CMP_INCL: begin
				o_hit = {2{in_range}};
			end
			DBE_CMP_EXCL: begin
				o_hit = {2{~in_range}};
			end
			default: begin
				o_hit = 2'h0;
			end
		endcase
		o_hit = o_hit & priv_ok;
	end
endmodule : dbe_iac_pair

/* tb/dbe_top_sva.sv */
// Concurrent checks on the ports of the debug event logic
`timescale 1ns/1ps
`include "dbe_map.svh"
module dbe_top_sva
	import dbe_pkg::*;
(
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic        i_instr_valid,
	input wire logic [31:0] i_instr_addr,
	input wire logic        i_branch_taken,
	input wire logic        i_branch_enable,
	input wire logic        i_trap_taken,
	input wire logic        i_trap_enable,
	input wire logic        i_instr_complete,
	input wire logic        i_instr_complete_event_enable,
	input wire logic        i_interrupt_taken,
	input wire logic        i_interrupt_event_enable,
	input wire logic        i_uncond_request,
	input wire logic        i_internal_mode,
	input wire logic        i_external_mode,
	input wire logic        i_wait_mode,
	input wire logic [3:0]  i_iac_enable,
	input wire logic [1:0]  i_pair_a_compare_mode,
	input wire logic [1:0]  i_comparator1_privilege_filter,
	input wire logic [31:0] i_instr_addr_compare1,
	input wire logic [17:0] i_status_clear,
	input wire logic [17:0] o_debug_event_status,
	input wire logic        o_trace_event,
	input wire logic        o_stop_request,
	input wire logic        o_debug_int_request
);
	logic [17:0] st;
	assign st = o_debug_event_status;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////
	a_instr_complete_event_record: assert property (i_instr_complete && i_instr_complete_event_enable
		|=> st[`DBE_ST_INSTR_COMPLETE_EVENT] && o_trace_event) else $error("instr_complete_event lost");
	a_interrupt_event_record: assert property (i_interrupt_taken && i_interrupt_event_enable
		|=> st[`DBE_ST_INTERRUPT_EVENT]) else $error("interrupt event lost");
	a_branch_cause: assert property ($rose(st[`DBE_ST_BRANCH]) |->
		$past(i_instr_valid && i_branch_taken && i_branch_enable))
		else $error("branch bit without taken branch");
	a_trap_cause: assert property ($rose(st[`DBE_ST_TRAP]) |->
		$past(i_instr_valid && i_trap_taken && i_trap_enable))
		else $error("trap bit without trap");
	a_status_sticky: assert property (st[`DBE_ST_INSTR_COMPLETE_EVENT] &&
		!i_status_clear[`DBE_ST_INSTR_COMPLETE_EVENT] |=> st[`DBE_ST_INSTR_COMPLETE_EVENT])
		else $error("status bit lost");
	a_clear_bit: assert property (i_status_clear[`DBE_ST_TRAP] &&
		!(i_instr_valid && i_trap_taken) |=> !st[`DBE_ST_TRAP])
		else $error("status bit not cleared");
	a_trace_quiet: assert property (!i_internal_mode &&
		!i_external_mode && !i_wait_mode
		|=> !o_stop_request && !o_debug_int_request)
		else $error("stop or interrupt in trace mode");
	a_uncond_seen: assert property ($rose(i_uncond_request)
		|-> ##[2:8] st[`DBE_ST_UNCOND]) else $error("uncond event lost");
	a_iac_cause: assert property ($rose(st[`DBE_ST_IAC]) |->
		$past(i_instr_valid && i_iac_enable[0]))
		else $error("compare bit without enable");
	a_exact_hit: assert property (i_instr_valid && i_iac_enable[0] &&
		i_pair_a_compare_mode == 2'h0 &&
		i_comparator1_privilege_filter == 2'h0 &&
		i_instr_addr == i_instr_addr_compare1 |=> st[`DBE_ST_IAC])
		else $error("exact compare missed");
endmodule : dbe_top_sva

bind dbe_top dbe_top_sva u_sva (.*);

/* tb/dbe_jtag_model.sv */
// External debug interface raising the unconditional request pin
`timescale 1ns/1ps
module dbe_jtag_model (
	input  wire logic i_clock,
	input  wire logic i_fire,
	output logic      o_request
);
	logic [2:0] cnt_q = 3'h0;
	// Pin held high six cycles so the synchroniser sees it
	always @(posedge i_clock) begin
		if (i_fire)
			cnt_q <= 3'h6;
		else if (cnt_q != 3'h0)
			cnt_q <= cnt_q - 3'h1;
	end
	assign o_request = (cnt_q != 3'h0);
endmodule : dbe_jtag_model

/* tb/tb_top.sv */
// Directed tests of the debug event logic
`timescale 1ns/1ps
`include "dbe_map.svh"
module tb_top
	import dbe_pkg::*;
;
	logic i_clock = 1'b0, i_rst = 1'b1, i_instr_valid = 1'b0, fire = 1'b0;
	logic i_problem_state_bit = 1'b0, i_branch_taken = 1'b0;
	logic i_trap_taken = 1'b0, i_return_exec = 1'b0, i_ls_valid = 1'b0;
	logic i_instr_complete = 1'b0, i_interrupt_taken = 1'b0;
	logic i_ls_write = 1'b0, i_internal_mode = 1'b0, i_external_mode = 1'b0;
	logic i_branch_enable = 1'b0, i_trap_enable = 1'b0, i_wait_mode = 1'b0;
	logic i_return_enable = 1'b0, i_instr_complete_event_enable = 1'b0, i_interrupt_event_enable = 1'b0;
	logic i_pair_a_toggle_enable = 1'b0, i_pair_b_toggle_enable = 1'b0;
	logic i_debug_int_allowed = 1'b0, i_uncond_request;
	logic o_trace_event, o_stop_request, o_debug_int_request;
	logic [3:0] i_iac_enable = '0;
	logic [1:0] i_dac_read_enable = '0, i_dac_write_enable = '0;
	logic [1:0] i_dvc_enable = '0, i_pair_a_compare_mode = '0;
	logic [1:0] i_pair_b_compare_mode = '0;
	logic [1:0] i_comparator1_privilege_filter = '0;
	logic [1:0] i_comparator2_privilege_filter = '0;
	logic [1:0] i_comparator3_privilege_filter = '0;
	logic [1:0] i_comparator4_privilege_filter = '0;
	logic [31:0] i_instr_addr = '0, i_ls_addr = '0, i_ls_data = '0;
	logic [31:0] i_instr_addr_compare1 = 32'h100, i_instr_addr_compare2 = 32'h200;
	logic [31:0] i_instr_addr_compare3 = 32'h100, i_instr_addr_compare4 = 32'h200;
	logic [31:0] i_data_addr_compare1 = 32'h2000, i_data_addr_compare2 = 32'h3000;
	logic [31:0] i_data_value_compare1 = 32'h55AA0F0F;
	logic [31:0] i_data_value_compare2 = 32'h12345678;
	logic [17:0] i_status_clear = '0, o_debug_event_status, clr_mask = '1;
	int n_fail = 0, n_checks = 0, cycles = 0;
	int bitpos [5] = '{`DBE_ST_BRANCH, `DBE_ST_TRAP, `DBE_ST_RETURN,
		`DBE_ST_INSTR_COMPLETE_EVENT, `DBE_ST_INTERRUPT_EVENT};

	dbe_top DUT (.*);
	dbe_jtag_model u_jtag (.i_clock(i_clock), .i_fire(fire),
		.o_request(i_uncond_request));

	always #2.5 i_clock = ~i_clock;
	////////////////////////////////////////////////////////////////////////
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 4000) begin
			n_fail++;
			finish_test;
		end
	end
	task step;
		@(posedge i_clock);
		#1;
	endtask : step
	task chk_st(input logic [17:0] exp);
		n_checks++;
		if (o_debug_event_status !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: status %h expected %h", $time,
				o_debug_event_status, exp);
		end
	endtask : chk_st
	task chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: pulse %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task clr;
		i_status_clear = clr_mask;
		step;
		i_status_clear = '0;
	endtask : clr
	task ev(input int k);
		clr;
		i_instr_valid = (k < 3) || (k == 5);
		i_branch_taken = (k == 0);
		i_trap_taken = (k == 1);
		i_return_exec = (k == 2);
		i_instr_complete = (k == 3);
		i_interrupt_taken = (k == 4);
		step;
		{i_instr_valid, i_branch_taken, i_trap_taken, i_return_exec} = '0;
		{i_instr_complete, i_interrupt_taken} = '0;
	endtask : ev
	task ia(input logic [31:0] addr, input logic pr);
		clr;
		i_instr_addr = addr;
		i_problem_state_bit = pr;
		i_instr_valid = 1'b1;
		step;
		i_instr_valid = 1'b0;
	endtask : ia
	task ls(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		clr;
		{i_ls_valid, i_ls_write, i_ls_addr, i_ls_data} = {1'b1, wr, addr, data};
		step;
		i_ls_valid = 1'b0;
	endtask : ls
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) step;
		i_rst = 1'b0;
		chk_st('0);
		for (int k = 0; k < 5; k++) begin
			{i_interrupt_event_enable, i_instr_complete_event_enable, i_return_enable} = '0;
			{i_trap_enable, i_branch_enable} = '0;
			ev(k);
			chk_st('0);
			{i_interrupt_event_enable, i_instr_complete_event_enable, i_return_enable} = '1;
			{i_trap_enable, i_branch_enable} = '1;
			ev(k);
			chk_st(18'h1 << bitpos[k]);
			chk_bit(o_trace_event, 1'b1);
			chk_bit(o_stop_request, 1'b0);
		end
		ev(5);
		chk_st('0);
		ev(3);
		i_interrupt_taken = 1'b1;
		step;
		i_interrupt_taken = 1'b0;
		chk_st(18'h6000);
		$display("test single events done");
		i_internal_mode = 1'b1;
		i_debug_int_allowed = 1'b1;
		ev(3);
		chk_bit(o_debug_int_request, 1'b1);
		i_external_mode = 1'b1;
		ev(3);
		chk_bit(o_stop_request, 1'b1);
		chk_bit(o_debug_int_request, 1'b0);
		{i_internal_mode, i_external_mode} = '0;
		i_wait_mode = 1'b1;
		ev(3);
		chk_bit(o_stop_request, 1'b1);
		i_internal_mode = 1'b1;
		ev(3);
		chk_bit(o_stop_request, 1'b0);
		chk_bit(o_debug_int_request, 1'b1);
		{i_internal_mode, i_wait_mode, i_instr_complete_event_enable} = '0;
		$display("test debug modes done");
		i_instr_addr_compare3 = 32'h300;
		i_instr_addr_compare4 = 32'h400;
		i_iac_enable = 4'hF;
		ia(32'h200, 1'b0);
		chk_st(18'h2);
		ia(32'h204, 1'b0);
		chk_st('0);
		i_comparator2_privilege_filter = 2'h3;
		ia(32'h200, 1'b0);
		chk_st('0);
		ia(32'h200, 1'b1);
		chk_st(18'h2);
		i_comparator2_privilege_filter = 2'h2;
		ia(32'h200, 1'b1);
		chk_st('0);
		ia(32'h200, 1'b0);
		chk_st(18'h2);
		$display("test exact compare done");
		{i_instr_addr_compare3, i_instr_addr_compare4} = {32'h100, 32'h200};
		i_comparator2_privilege_filter = 2'h0;
		i_iac_enable = 4'hC;
		i_pair_b_compare_mode = 2'h2;
		ia(32'h100, 1'b0);
		chk_st(18'hC);
		ia(32'h200, 1'b0);
		chk_st('0);
		i_iac_enable = 4'h5;
		i_pair_b_compare_mode = 2'h3;
		ia(32'h100, 1'b0);
		chk_st(18'h1);
		ia(32'h200, 1'b0);
		chk_st(18'h4);
		ia(32'h1FF, 1'b0);
		chk_st('0);
		ia(32'hFF, 1'b0);
		chk_st(18'h4);
		i_pair_b_compare_mode = 2'h0;
		i_iac_enable = 4'h1;
		i_pair_a_compare_mode = 2'h2;
		i_pair_a_toggle_enable = 1'b1;
		clr_mask = 18'h0FFFF;
		ia(32'h150, 1'b0);
		chk_st(18'h10001);
		ia(32'h150, 1'b0);
		chk_st(18'h10000);
		ia(32'h50, 1'b0);
		chk_st(18'h1);
		clr_mask = '1;
		{i_pair_a_toggle_enable, i_pair_a_compare_mode, i_iac_enable} = '0;
		$display("test range compare done");
		{i_dac_read_enable, i_dac_write_enable, i_dvc_enable} = 6'h15;
		ls(1'b0, 32'h2000, 32'h55AA0F0F);
		chk_st(18'h110);
		ls(1'b0, 32'h2000, 32'h55AA0F0E);
		chk_st(18'h10);
		ls(1'b1, 32'h2000, 32'h0);
		chk_st(18'h40);
		ls(1'b0, 32'h2004, 32'h55AA0F0F);
		chk_st('0);
		{i_dac_read_enable, i_dac_write_enable, i_dvc_enable} = 6'h3F;
		ls(1'b1, 32'h3000, 32'h12345678);
		chk_st(18'h280);
		$display("test data compare done");
		clr;
		fire = 1'b1;
		step;
		fire = 1'b0;
		for (int i = 0; i < 12 && !o_debug_event_status[15]; i++)
			step;
		chk_st(18'h8000);
		i_rst = 1'b1;
		step;
		i_rst = 1'b0;
		chk_st('0);
		chk_bit(o_trace_event, 1'b0);
		$display("test unconditional and reset done");
		finish_test;
	end
endmodule : tb_top
